// ---- sim/accum_alu_props.sv ----
// Bus-side assertions for the ALU register block.
`timescale 1ns/1ps
module alu_props
    import alu_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic irq
);
    // ==========================================================
    // Shadow state
    // Software is the only writer of source B, so a shadow stays exact.
    ahb_phase_s ph_ff, nxt_ph;
    logic [31:0] shb_ff, nxt_shb;
    logic [1:0] en_ff, nxt_en;
    logic done_ff, nxt_done;
    logic rd_dp;
    logic wr_dp;
    logic [4:0] ofs;

    assign rd_dp = ph_ff.valid && !ph_ff.write;
    assign wr_dp = ph_ff.valid && ph_ff.write;
    assign ofs = {ph_ff.addr[4:2], 2'h0};

    always_comb begin
        nxt_ph.valid = hsel && hready && htrans == HTRANS_NONSEQ;
        nxt_ph.write = hwrite;
        nxt_ph.addr = haddr[4:0];
        nxt_shb = shb_ff;
        nxt_en = en_ff;
        nxt_done = done_ff;
        if (wr_dp && ofs == OFS_SRC_B)
            nxt_shb = hwdata;
        if (wr_dp && ofs == OFS_IRQ_ENABLE)
            nxt_en = hwdata[1:0];
        if (wr_dp && ofs == OFS_IRQ_CLEAR && hwdata[0])
            nxt_done = 1'b0;
        if (wr_dp && ofs == OFS_CMD)
            nxt_done = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_ff <= '0;
            shb_ff <= DATA_RESET;
            en_ff <= IRQ_RESET;
            done_ff <= 1'b0;
        end else begin
            ph_ff <= nxt_ph;
            shb_ff <= nxt_shb;
            en_ff <= nxt_en;
            done_ff <= nxt_done;
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_okay;
        hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("not zero-wait OKAY");
    property p_rd_idle;
        !rd_dp |-> hrdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray rdata");
    property p_proc_stat;
        rd_dp && ofs == OFS_PROC_STATUS |-> hrdata[31:4] == 28'h0;
    endproperty
    a_proc_stat: assert property (p_proc_stat)
        else $error("status word too wide");
    property p_wo;
        rd_dp && (ofs == OFS_CMD || ofs == OFS_IRQ_CLEAR) |-> hrdata == 32'h0;
    endproperty
    a_wo: assert property (p_wo) else $error("write-only read not 0");
    property p_srcb;
        rd_dp && ofs == OFS_SRC_B |-> hrdata == shb_ff;
    endproperty
    a_srcb: assert property (p_srcb) else $error("source B altered");
    property p_stat;
        rd_dp && ofs == OFS_IRQ_STATUS |-> hrdata[31:2] == 30'h0
            && hrdata[0] == done_ff;
    endproperty
    a_stat: assert property (p_stat) else $error("done bit wrong");
    property p_irq_rise;
        wr_dp && ofs == OFS_CMD && en_ff[0] |=> irq;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq late");
    property p_irq_clear;
        wr_dp && ofs == OFS_IRQ_CLEAR && hwdata[1:0] == 2'h3 |=> !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq kept");
    property p_irq_hold;
        !wr_dp |=> $stable(irq);
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq moved");
endmodule

bind accum_compare_logic_saturate_alu alu_props #(.ADDR_W(ADDR_W)) u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq)
);

// ---- sim/accum_compare_logic_saturate_alu_tb.sv ----
// Self-checking bench for the ALU register block over AHB-Lite.
`timescale 1ns/1ps
module accum_compare_logic_saturate_alu_tb
    import alu_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic [31:0] hrdata;
    int num_errors = 0;
    int checks = 0;

    assign hready = hreadyout;

    accum_compare_logic_saturate_alu #(.ADDR_W(32)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .irq(irq)
    );

    initial begin
        forever #2 hclk = ~hclk;
    end

    // ==========================================================
    // Bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read data is taken before this edge's register updates land.
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {27'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, a, 32'h0, got);
        chk(got, exp);
    endtask

    // Short forms write source A and leave the destination alone.
    task automatic ex(input logic [4:0] o, input logic [31:0] sa, sb, d, ed,
                      input logic [8:0] imm = 9'h0, input logic ui = 1'b0,
                      input logic [4:0] pa = 5'h0, pb = 5'h0);
        alu_cmd_s c;
        logic sh;
        c = '0;
        c.op = o;
        c.use_imm = ui;
        c.imm_nine_bit = imm;
        c.bit_pos_a = pa;
        c.bit_pos_b = pb;
        sh = o == 5'h8 || o == 5'hC || o == 5'hE;
        wr(OFS_SRC_A, sa);
        wr(OFS_SRC_B, sb);
        wr(OFS_DEST, d);
        wr(OFS_CMD, c);
        rdc(OFS_DEST, sh ? d : ed);
        rdc(OFS_SRC_A, sh ? ed : sa);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rdc(5'(i * 4), 32'h0);
        ex(5'h0, 32'hFFFFFFFF, 32'h1, 32'hA5A5A5A4, 32'hA5A5A5A5);
        ex(5'h0, 32'h1, 32'h0, 32'h3, 32'h3);
        ex(5'h0, 32'hFFFFFFFE, 32'h0, 32'h0, 32'h1, 9'h1FF, 1'b1);
        ex(5'h1, 32'hFFFFFFFF, 32'h1, 32'hA5A5A5A4, 32'hA5A5A5A4);
        ex(5'h1, 32'h1, 32'hFFFFFFFF, 32'h0, 32'h1);
        ex(5'h1, 32'hFFFFFFFE, 32'h0, 32'h0, 32'h0, 9'h1FF, 1'b1);
        ex(5'h2, 32'h5, 32'h5, 32'hFFFFFFFE, 32'hFFFFFFFE);
        ex(5'h2, 32'h5, 32'h6, 32'h0, 32'h1);
        ex(5'h2, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 9'h1FF, 1'b1);
        for (int i = 0; i < 4; i++) begin
            ex(5'h3, {23'h0, i[0], 8'hFF}, {i[1], 31'h7FFFFFFF}, 32'h2,
               {31'h0, i[0] | i[1]}, 9'h0, 1'b0, 5'h8, 5'h1F);
            ex(5'h4, {23'h0, i[0], 8'hFF}, {i[1], 31'h7FFFFFFF}, 32'h2,
               {31'h0, i[0] | !i[1]}, 9'h0, 1'b0, 5'h8, 5'h1F);
        end
        ex(5'h5, 32'hF0, 32'hFFFFFF0F, 32'h0, 32'hF0);
        ex(5'h5, 32'h0, 32'h0, 32'h0, 32'hFFFFFE00, 9'h1FF, 1'b1);
        ex(5'h7, 32'h1, 32'h0, 32'h0, 32'h7D, 9'h7E);
        ex(5'h7, 32'h0, 32'h0, 32'h0, 32'hFFFFFFFF, 9'h1FF);
        ex(5'h8, 32'h5, 32'h0, 32'h9, 32'hFFFFFFFB);
        ex(5'h9, 32'h80000001, 32'h0, 32'h0, 32'h7FFFFFFF, 9'hFF);
        ex(5'h9, 32'h7FFFFFFF, 32'h0, 32'h0, 32'h80000000, 9'h1FE);
        ex(5'hA, 32'h0, 32'h0, 32'h0, 32'h1FF, 9'h1FF);
        ex(5'hB, 32'hFFFFFF00, 32'h0, 32'h0, 32'hFFFFFF80);
        ex(5'hB, 32'h80, 32'h0, 32'h0, 32'h7F);
        ex(5'hB, 32'hFFFFFF80, 32'h0, 32'h0, 32'hFFFFFF80);
        ex(5'hC, 32'hFFFF0000, 32'h0, 32'h3, 32'hFFFFFF80);
        ex(5'hD, 32'h100, 32'h0, 32'h0, 32'hFF);
        ex(5'hD, 32'hFE, 32'h0, 32'h0, 32'hFE);
        ex(5'hE, 32'h12345678, 32'h0, 32'h3, 32'hFF);
        ex(5'hF, 32'h8000, 32'h0, 32'h0, 32'h7FFF);
        ex(5'hF, 32'hFFFF7FFF, 32'h0, 32'h0, 32'hFFFF8000);
        wr(OFS_IRQ_CLEAR, 32'h3);
        wr(OFS_IRQ_ENABLE, 32'h3);
        ex(5'h6, 32'h0, 32'h0, 32'h0, 32'h0);
        rdc(OFS_PROC_STATUS, 32'h0);
        ex(5'h7, 32'h80000000, 32'h0, 32'h0, 32'h80000000);
        rdc(OFS_PROC_STATUS, 32'hF);
        rdc(OFS_IRQ_STATUS, 32'h3);
        chk({31'h0, irq}, 32'h1);
        ex(5'h6, 32'h0, 32'h0, 32'h0, 32'h0);
        ex(5'h9, 32'h80000000, 32'h0, 32'h0, 32'h7FFFFFFF);
        rdc(OFS_PROC_STATUS, 32'hF);
        ex(5'h6, 32'h0, 32'h0, 32'h0, 32'h0);
        ex(5'hA, 32'h6, 32'h0, 32'h0, 32'h0, 9'h5);
        rdc(OFS_PROC_STATUS, 32'h3);
        ex(5'h10, 32'h1, 32'h2, 32'h3, 32'h3);
        rdc(OFS_PROC_STATUS, 32'h3);
        wr(OFS_IRQ_CLEAR, 32'h3);
        rdc(OFS_IRQ_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_ENABLE, 32'h0);
        ex(5'h7, 32'h1, 32'h0, 32'h0, 32'hFFFFFFFF);
        wr(OFS_IRQ_STATUS, 32'h0);
        rdc(OFS_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        close_out();
    end

    initial begin
        repeat (5000) @(posedge hclk);
        num_errors++;
        close_out();
    end
endmodule

// ---- verilog/accum_compare_logic_saturate_alu.sv ----
// AHB-Lite ALU block: accumulating compares, OR logic, rsub and clamps.
`timescale 1ns/1ps
// ==========================================================
// Function
// RL1 - Signed less-than, sign-extended immediate, ORed into bit 0 only.
// RL2 - Unsigned less-than, zero-extended immediate, ORed into bit 0 only.
// RL3 - Not-equal compare ORed into destination bit 0, upper bits kept.
// RL4 - Not-equal immediate is sign-extended to 32 bits before comparing.
// RL5 - Bit OR of two selected source bits into bit 0, rest cleared.
// RL6 - Bit OR with inverted second bit into bit 0, rest cleared.
// RL7 - Bitwise OR of A with complement of B or zero-extended immediate.
// RL8 - Flag reset clears the four overflow flags and sets only the done IRQ status bit.
// RL9 - Sign-extended immediate minus A into destination, four flags updated.
// RL10 - Short reverse subtract negates source A in place.
// RL11 - Saturating reverse subtract, signed or unsigned, sets four flags.
// RL12 - Saturation clamps to the extreme value in the overflow direction.
// RL13 - Signed byte clamp of A to -128..127 into destination.
// RL14 - Short signed byte clamp of A in place.
// RL15 - Unsigned byte clamp of A to 255 into destination.
// RL16 - Short unsigned byte clamp of A in place.
// RL17 - Signed halfword clamp of A to -32768..32767 into destination.
module accum_compare_logic_saturate_alu
    import alu_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq
);

    // ==========================================================
    // Elaboration checks.
    if (ADDR_W < 5) begin : g_addr_check
        $error("ADDR_W must be at least 5");
    end

    // ==========================================================
    // Helpers.
    function automatic logic [31:0] sign_ext9(input logic [8:0] v);
        return {{23{v[8]}}, v};
    endfunction

    function automatic logic [31:0] zero_ext9(input logic [8:0] v);
        return {23'h000000, v};
    endfunction

    function automatic logic [31:0] clamp_signed(input logic [31:0] v,
                                                 input logic [31:0] lo,
                                                 input logic [31:0] hi);
        if ($signed(v) < $signed(lo)) begin
            return lo;
        end else if ($signed(v) > $signed(hi)) begin
            return hi;
        end
        return v;
    endfunction

    function automatic logic [31:0] clamp_unsigned(input logic [31:0] v,
                                                   input logic [31:0] hi);
        return (v > hi) ? hi : v;
    endfunction

    // The early flag marks a result whose top two bits differ, that is one
    // that a further doubling would overflow.
    function automatic logic early_ofl(input logic [31:0] v);
        return v[31] ^ v[30];
    endfunction

    // ==========================================================
    // Bus slave state.
    ahb_phase_s phase_ff, nxt_phase;
    logic [31:0] src_a_ff, nxt_src_a;
    logic [31:0] src_b_ff, nxt_src_b;
    logic [31:0] dest_ff, nxt_dest;
    logic [3:0] stat_ff, nxt_stat;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic [1:0] irq_status_ff, nxt_irq_status;
    logic [1:0] irq_enable_ff, nxt_irq_enable;

    logic wr_en;
    logic cmd_go;
    alu_cmd_s cmd;

    // Zero wait states; every transfer is answered OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    // Transfer size is not decoded: every register is one whole word.
    assign wr_en = phase_ff.valid && phase_ff.write;
    assign cmd_go = wr_en && (phase_ff.addr == OFS_CMD);
    assign cmd = alu_cmd_s'(hwdata);

    always_comb begin
        nxt_phase.valid = hsel && hready && (htrans == HTRANS_NONSEQ);
        nxt_phase.write = hwrite;
        nxt_phase.addr = {haddr[4:2], 2'b00};
    end

    // Read data is registered at the end of the address phase from the
    // next-state values, so a read right after a write or a command sees
    // the new contents with no wait state. The price is a longer path from
    // the write data through the datapath into the read register.
    always_comb begin
        nxt_hrdata = 32'h0000_0000;
        if (nxt_phase.valid && !nxt_phase.write) begin
            case (nxt_phase.addr)
                OFS_SRC_A: nxt_hrdata = nxt_src_a;
                OFS_SRC_B: nxt_hrdata = nxt_src_b;
                OFS_DEST: nxt_hrdata = nxt_dest;
                OFS_PROC_STATUS: nxt_hrdata = {28'h0, nxt_stat};
                OFS_IRQ_STATUS: nxt_hrdata = {30'h0, nxt_irq_status};
                OFS_IRQ_ENABLE: nxt_hrdata = {30'h0, nxt_irq_enable};
                default: nxt_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Datapath.
    logic [31:0] op_b;
    logic [31:0] alu_res;
    logic [32:0] diff;
    logic res_to_a;
    logic res_valid;
    logic flags_upd;
    logic ofl;

    always_comb begin
        op_b = src_b_ff;
        alu_res = dest_ff;
        diff = 33'h0_0000_0000;
        res_to_a = 1'b0;
        res_valid = 1'b1;
        flags_upd = 1'b0;
        ofl = 1'b0;
        case (alu_op_e'(cmd.op))
            OP_ACCUM_LESS_THAN_SIGNED: begin
                // RL1 signed accumulate
                op_b = cmd.use_imm ? sign_ext9(cmd.imm_nine_bit) : src_b_ff;
                alu_res = {dest_ff[31:1],
                           dest_ff[0] | ($signed(src_a_ff) < $signed(op_b))};
            end
            OP_ACCUM_LESS_THAN_UNSIGNED: begin
                // RL2 unsigned accumulate
                op_b = cmd.use_imm ? zero_ext9(cmd.imm_nine_bit) : src_b_ff;
                alu_res = {dest_ff[31:1], dest_ff[0] | (src_a_ff < op_b)};
            end
            OP_ACCUM_NOT_EQUAL: begin
                // RL4 sign-extended immediate
                op_b = cmd.use_imm ? sign_ext9(cmd.imm_nine_bit) : src_b_ff;
                // RL3 not-equal accumulate
                alu_res = {dest_ff[31:1], dest_ff[0] | (src_a_ff != op_b)};
            end
            OP_BIT_OR: begin
                // RL5 single-bit OR
                alu_res = {31'h00000000,
                           src_a_ff[cmd.bit_pos_a] | src_b_ff[cmd.bit_pos_b]};
            end
            OP_BIT_OR_NOT: begin
                // RL6 single-bit OR-not
                alu_res = {31'h00000000,
                           src_a_ff[cmd.bit_pos_a] | ~src_b_ff[cmd.bit_pos_b]};
            end
            OP_OR_NOT: begin
                // RL7 bitwise OR-not
                op_b = cmd.use_imm ? zero_ext9(cmd.imm_nine_bit) : src_b_ff;
                alu_res = src_a_ff | ~op_b;
            end
            OP_CLEAR_OFL: begin
                res_valid = 1'b0;
            end
            OP_RSUB, OP_RSUB_SHORT: begin
                // RL9 immediate minus source
                op_b = (cmd.op == OP_RSUB) ? sign_ext9(cmd.imm_nine_bit)
                                           : 32'h0000_0000;
                // RL10 short form negates in place
                diff = {op_b[31], op_b} - {src_a_ff[31], src_a_ff};
                alu_res = diff[31:0];
                ofl = diff[32] ^ diff[31];
                flags_upd = 1'b1;
                res_to_a = (cmd.op == OP_RSUB_SHORT);
            end
            OP_RSUB_SAT_SIGNED: begin
                // RL11 signed saturating form
                op_b = sign_ext9(cmd.imm_nine_bit);
                diff = {op_b[31], op_b} - {src_a_ff[31], src_a_ff};
                ofl = diff[32] ^ diff[31];
                // RL12 clamp by direction
                alu_res = !ofl ? diff[31:0]
                               : (diff[32] ? WORD_S_MIN : WORD_S_MAX);
                flags_upd = 1'b1;
            end
            OP_RSUB_SAT_UNSIGNED: begin
                // RL11 unsigned saturating form
                op_b = zero_ext9(cmd.imm_nine_bit);
                diff = {1'b0, op_b} - {1'b0, src_a_ff};
                ofl = diff[32];
                // RL12 unsigned borrow clamps to zero
                alu_res = ofl ? 32'h0000_0000 : diff[31:0];
                flags_upd = 1'b1;
            end
            OP_CLAMP_SIGNED_BYTE, OP_CLAMP_SIGNED_BYTE_SHORT: begin
                // RL13 signed byte clamp
                alu_res = clamp_signed(src_a_ff, BYTE_S_MIN, BYTE_S_MAX);
                // RL14 short form in place
                res_to_a = (cmd.op == OP_CLAMP_SIGNED_BYTE_SHORT);
            end
            OP_CLAMP_UNSIGNED_BYTE, OP_CLAMP_UNSIGNED_BYTE_SHORT: begin
                // RL15 unsigned byte clamp
                alu_res = clamp_unsigned(src_a_ff, BYTE_U_MAX);
                // RL16 short form in place
                res_to_a = (cmd.op == OP_CLAMP_UNSIGNED_BYTE_SHORT);
            end
            OP_CLAMP_SIGNED_HALF: begin
                // RL17 signed halfword clamp
                alu_res = clamp_signed(src_a_ff, HALF_S_MIN, HALF_S_MAX);
            end
            default: begin
                res_valid = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Register file next state.
    always_comb begin
        nxt_src_a = src_a_ff;
        nxt_src_b = src_b_ff;
        nxt_dest = dest_ff;
        nxt_stat = stat_ff;
        nxt_irq_enable = irq_enable_ff;
        nxt_irq_status = irq_status_ff;
        if (wr_en) begin
            case (phase_ff.addr)
                OFS_SRC_A: nxt_src_a = hwdata;
                OFS_SRC_B: nxt_src_b = hwdata;
                OFS_DEST: nxt_dest = hwdata;
                OFS_PROC_STATUS: nxt_stat = hwdata[3:0];
                OFS_IRQ_ENABLE: nxt_irq_enable = hwdata[1:0];
                OFS_IRQ_CLEAR: nxt_irq_status = irq_status_ff & ~hwdata[1:0];
                default: nxt_irq_status = irq_status_ff;
            endcase
        end
        if (cmd_go) begin
            if (res_valid && res_to_a) begin
                nxt_src_a = alu_res;
            end else if (res_valid) begin
                nxt_dest = alu_res;
            end
            if (alu_op_e'(cmd.op) == OP_CLEAR_OFL) begin
                // RL8 clear overflow flags
                nxt_stat = STAT_RESET;
            end else if (flags_upd) begin
                // RL9 overflow flags follow the result
                nxt_stat[STAT_OFL] = ofl;
                nxt_stat[STAT_STICKY_OFL] = stat_ff[STAT_STICKY_OFL] | ofl;
                nxt_stat[STAT_EARLY_OFL] = early_ofl(alu_res);
                nxt_stat[STAT_STICKY_EARLY] = stat_ff[STAT_STICKY_EARLY]
                                              | early_ofl(alu_res);
            end
            // Events are set after any clear so a same-cycle event wins.
            nxt_irq_status[IRQ_DONE] = 1'b1;
            if (flags_upd && ofl) begin
                nxt_irq_status[IRQ_OFL] = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_ff <= '0;
            src_a_ff <= DATA_RESET;
            src_b_ff <= DATA_RESET;
            dest_ff <= DATA_RESET;
            stat_ff <= STAT_RESET;
            hrdata_ff <= DATA_RESET;
            irq_status_ff <= IRQ_RESET;
            irq_enable_ff <= IRQ_RESET;
        end else begin
            phase_ff <= nxt_phase;
            src_a_ff <= nxt_src_a;
            src_b_ff <= nxt_src_b;
            dest_ff <= nxt_dest;
            stat_ff <= nxt_stat;
            hrdata_ff <= nxt_hrdata;
            irq_status_ff <= nxt_irq_status;
            irq_enable_ff <= nxt_irq_enable;
        end
    end

    assign irq = |(irq_status_ff & irq_enable_ff);

endmodule

// ---- verilog/alu_pkg.sv ----
// Package with the register map, field layouts and opcodes of the ALU block.
package alu_pkg;

    // ==========================================================
    // Register byte offsets.
    localparam logic [4:0] OFS_SRC_A = 5'h00;
    localparam logic [4:0] OFS_SRC_B = 5'h04;
    localparam logic [4:0] OFS_DEST = 5'h08;
    localparam logic [4:0] OFS_CMD = 5'h0C;
    localparam logic [4:0] OFS_PROC_STATUS = 5'h10;
    localparam logic [4:0] OFS_IRQ_STATUS = 5'h14;
    localparam logic [4:0] OFS_IRQ_ENABLE = 5'h18;
    localparam logic [4:0] OFS_IRQ_CLEAR = 5'h1C;

    // ==========================================================
    // Field positions and reset values.
    localparam int STAT_OFL = 0;
    localparam int STAT_STICKY_OFL = 1;
    localparam int STAT_EARLY_OFL = 2;
    localparam int STAT_STICKY_EARLY = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OFL = 1;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
    localparam logic [3:0] STAT_RESET = 4'h0;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] BYTE_S_MIN = 32'hFFFF_FF80;
    localparam logic [31:0] BYTE_S_MAX = 32'h0000_007F;
    localparam logic [31:0] BYTE_U_MAX = 32'h0000_00FF;
    localparam logic [31:0] HALF_S_MIN = 32'hFFFF_8000;
    localparam logic [31:0] HALF_S_MAX = 32'h0000_7FFF;
    localparam logic [31:0] WORD_S_MIN = 32'h8000_0000;
    localparam logic [31:0] WORD_S_MAX = 32'h7FFF_FFFF;

    // ==========================================================
    // Operations, numbered from zero in this order.
    typedef enum logic [4:0] {
        OP_ACCUM_LESS_THAN_SIGNED,
        OP_ACCUM_LESS_THAN_UNSIGNED,
        OP_ACCUM_NOT_EQUAL,
        OP_BIT_OR,
        OP_BIT_OR_NOT,
        OP_OR_NOT,
        OP_CLEAR_OFL,
        OP_RSUB,
        OP_RSUB_SHORT,
        OP_RSUB_SAT_SIGNED,
        OP_RSUB_SAT_UNSIGNED,
        OP_CLAMP_SIGNED_BYTE,
        OP_CLAMP_SIGNED_BYTE_SHORT,
        OP_CLAMP_UNSIGNED_BYTE,
        OP_CLAMP_UNSIGNED_BYTE_SHORT,
        OP_CLAMP_SIGNED_HALF
    } alu_op_e;

    // ==========================================================
    // Command word written to the command register.
    typedef struct packed {
        logic [8:0] imm_nine_bit;
        logic [1:0] rsvd2;
        logic [4:0] bit_pos_b;
        logic [2:0] rsvd1;
        logic [4:0] bit_pos_a;
        logic use_imm;
        logic [1:0] rsvd0;
        logic [4:0] op;
    } alu_cmd_s;

    // Address phase captured for the following data phase.
    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] addr;
    } ahb_phase_s;

endpackage
